// ===== spqm_consts.svh
// Constants for the stacking port queue mapper
// Operation
// - Fast stacking ports twelve queues, others eight
// - First device assigns and carries internal priority; here req_in.pri is carried unchanged and first_dev has no effect on it
// - Data queue chosen by priority map lookup
// - Data traffic uses only queues zero to seven
// - Priority map entry holds three-bit queue
// - Software queue 0-31 mapped to eight queues
// - Fast stacking port uses separate twelve-queue map
// - Trap reason gives queue, then same mapping
// - Trap to master uses twelve-queue stacking map
// - Processor-to-normal map entry three bits
// - Fast map four bits, codes above eleven invalid
// - Stacking adds trap and copy to master
`ifndef SPQM_CONSTS_SVH
`define SPQM_CONSTS_SVH
// ==========================================
// Register map (table selected by upper address bits, entry index in lower bits)
`define SPQM_ADDR_W 8
`define SPQM_BASE_PRI 8'h00
`define SPQM_BASE_NQ 8'h20
`define SPQM_BASE_FQ 8'h40
`define SPQM_BASE_TRAP 8'h60
`define SPQM_ADDR_CTRL 8'h80
`define SPQM_ADDR_STAT 8'h81
// ==========================================
// Field sizes and limits
`define SPQM_PRI_N 8
`define SPQM_CPUQ_N 32
`define SPQM_REASON_N 32
`define SPQM_FAST_MAX 4'hB
`define SPQM_NORMAL_Q 4'h8
`define SPQM_FAST_Q 4'hC
`define SPQM_DATA_MAX 4'h7
`endif

// ===== spqm_pkg.sv
// Types for the stacking port queue mapper
package spqm_pkg;
   typedef enum logic [1:0] {
      SPQM_SRC_DATA = 2'b00,
      SPQM_SRC_CPU = 2'b01,
      SPQM_SRC_TRAP = 2'b10
   } spqm_src_type;
   typedef enum logic [2:0] {
      SPQM_ACT_FWD = 3'b000,
      SPQM_ACT_TRAP_LOCAL = 3'b001,
      SPQM_ACT_COPY_LOCAL = 3'b010,
      SPQM_ACT_TRAP_MASTER = 3'b011,
      SPQM_ACT_COPY_MASTER = 3'b100
   } spqm_act_type;
   typedef struct packed {
      logic valid;
      spqm_src_type src;
      spqm_act_type act;
      logic fast_port;
      logic [2:0] pri;
      logic [4:0] cpu_q;
      logic [4:0] reason;
   } spqm_req_type;
   typedef struct packed {
      logic valid;
      logic [3:0] queue;
      logic to_master;
      logic to_local;
      logic cfg_err;
      logic [2:0] pri;
   } spqm_res_type;
endpackage

// ===== spqm_table.sv
// Small mapping table memory with registered read data
`timescale 1ns/1ps
module spqm_table #(
   parameter int DEPTH = 32,
   parameter int WIDTH = 4,
   parameter int AW = 5
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Write port
   input wire logic wr_in,
   input wire logic [AW-1:0] waddr_in,
   input wire logic [WIDTH-1:0] wdata_in,
   // Read port A
   input wire logic [AW-1:0] raddr_a_in,
   output logic [WIDTH-1:0] rdata_a_out,
   // Read port B
   input wire logic [AW-1:0] raddr_b_in,
   output logic [WIDTH-1:0] rdata_b_out
);
   logic [WIDTH-1:0] mem [DEPTH];
   // ==========================================
   // Storage
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= '0;
         end
      end else if (wr_in) begin
         mem[waddr_in] <= wdata_in;
      end
   end
   // ==========================================
   // Registered reads
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_a_out <= '0;
         rdata_b_out <= '0;
      end else begin
         rdata_a_out <= mem[raddr_a_in];
         rdata_b_out <= mem[raddr_b_in];
      end
   end
endmodule // spqm_table

// ===== spqm_trap_queue.sv
// Trap reason to processor queue number table
`timescale 1ns/1ps
`include "spqm_consts.svh"
module spqm_trap_queue import spqm_pkg::*; (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Configuration write
   input wire logic wr_in,
   input wire logic [4:0] waddr_in,
   input wire logic [4:0] wdata_in,
   // Lookup
   input wire logic [4:0] reason_in,
   output logic [4:0] cpu_q_out,
   // Readback
   input wire logic [4:0] raddr_in,
   output logic [4:0] rdata_out
);
   spqm_table #(
      .DEPTH(`SPQM_REASON_N),
      .WIDTH(5),
      .AW(5)
   ) u_tab (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .wr_in(wr_in),
      .waddr_in(waddr_in),
      .wdata_in(wdata_in),
      .raddr_a_in(reason_in),
      .rdata_a_out(cpu_q_out),
      .raddr_b_in(raddr_in),
      .rdata_b_out(rdata_out)
   );
endmodule // spqm_trap_queue

// ===== spqm_mapper.sv
// Stacking port egress queue mapper top
`timescale 1ns/1ps
`include "spqm_consts.svh"
module spqm_mapper import spqm_pkg::*; (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Register port
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   // Packet request
   input wire spqm_req_type req_in,
   // Packet result
   output spqm_res_type res_out
);
   // ==========================================
   // Address decode
   function automatic logic in_tab(input logic [7:0] a, input logic [7:0] base, input int n);
      in_tab = (a >= base) && (a < base + 8'(n));
   endfunction
   logic wr_pri, wr_nq, wr_fq, wr_trap, wr_ctrl;
   assign wr_pri = wr_in && in_tab(addr_in, `SPQM_BASE_PRI, `SPQM_PRI_N);
   assign wr_nq = wr_in && in_tab(addr_in, `SPQM_BASE_NQ, `SPQM_CPUQ_N);
   assign wr_fq = wr_in && in_tab(addr_in, `SPQM_BASE_FQ, `SPQM_CPUQ_N);
   assign wr_trap = wr_in && in_tab(addr_in, `SPQM_BASE_TRAP, `SPQM_REASON_N);
   assign wr_ctrl = wr_in && (addr_in == `SPQM_ADDR_CTRL);
   // ==========================================
   // Control: first-device enable
   logic first_dev;
   logic err_seen;
   logic [31:0] err_count;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         first_dev <= 1'b1;
      end else if (wr_ctrl) begin
         first_dev <= wdata_in[0];
      end
   end
   // ==========================================
   // Stage 1: trap reason lookup, priority carried
   spqm_req_type s1;
   logic [4:0] trap_q;
   logic [4:0] trap_rd;
   spqm_trap_queue u_trap (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .wr_in(wr_trap),
      .waddr_in(addr_in[4:0]),
      .wdata_in(wdata_in[4:0]),
      .reason_in(req_in.reason),
      .cpu_q_out(trap_q),
      .raddr_in(addr_in[4:0]),
      .rdata_out(trap_rd)
   );
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s1 <= '0;
      end else begin
         s1 <= req_in;
         // Internal priority is kept with the packet toward the next device
         if (!first_dev) begin
            s1.pri <= req_in.pri;
         end
      end
   end
   // Queue number chosen from trap reason for trapped packets
   logic [4:0] s1_cpuq;
   assign s1_cpuq = (s1.src == SPQM_SRC_TRAP) ? trap_q : s1.cpu_q;
   // ==========================================
   // Stage 2: map tables
   logic [2:0] pri_q, pri_rd;
   logic [2:0] nq_q, nq_rd;
   logic [3:0] fq_q, fq_rd;
   spqm_table #(.DEPTH(`SPQM_PRI_N), .WIDTH(3), .AW(3)) u_pri (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .wr_in(wr_pri),
      .waddr_in(addr_in[2:0]),
      .wdata_in(wdata_in[2:0]),
      .raddr_a_in(s1.pri),
      .rdata_a_out(pri_q),
      .raddr_b_in(addr_in[2:0]),
      .rdata_b_out(pri_rd)
   );
   spqm_table #(.DEPTH(`SPQM_CPUQ_N), .WIDTH(3), .AW(5)) u_nq (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .wr_in(wr_nq),
      .waddr_in(addr_in[4:0]),
      .wdata_in(wdata_in[2:0]),
      .raddr_a_in(s1_cpuq),
      .rdata_a_out(nq_q),
      .raddr_b_in(addr_in[4:0]),
      .rdata_b_out(nq_rd)
   );
   spqm_table #(.DEPTH(`SPQM_CPUQ_N), .WIDTH(4), .AW(5)) u_fq (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .wr_in(wr_fq),
      .waddr_in(addr_in[4:0]),
      .wdata_in(wdata_in[3:0]),
      .raddr_a_in(s1_cpuq),
      .rdata_a_out(fq_q),
      .raddr_b_in(addr_in[4:0]),
      .rdata_b_out(fq_rd)
   );
   spqm_req_type s2;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s2 <= '0;
      end else begin
         s2 <= s1;
      end
   end
   // ==========================================
   // Queue selection
   logic master_act, local_act, fast_sel, fast_bad;
   logic [3:0] next_queue;
   assign master_act = (s2.act == SPQM_ACT_TRAP_MASTER) || (s2.act == SPQM_ACT_COPY_MASTER);
   assign local_act = (s2.act == SPQM_ACT_TRAP_LOCAL) || (s2.act == SPQM_ACT_COPY_LOCAL) ||
                      (s2.act == SPQM_ACT_COPY_MASTER);
   // Master-bound trapped packets leave via the stacking port on its twelve queues
   assign fast_sel = s2.fast_port || (s2.src == SPQM_SRC_TRAP && master_act);
   function automatic logic fast_q_bad(input logic [3:0] q);
      fast_q_bad = q > `SPQM_FAST_MAX;
   endfunction
   assign fast_bad = fast_q_bad(fq_q);
   always_comb begin
      next_queue = 4'h0;
      case (s2.src)
         SPQM_SRC_DATA: begin
            next_queue = {1'b0, pri_q};
         end
         SPQM_SRC_CPU, SPQM_SRC_TRAP: begin
            if (fast_sel) begin
               next_queue = fast_bad ? `SPQM_FAST_MAX : fq_q;
            end else begin
               next_queue = {1'b0, nq_q};
            end
         end
         default: begin
            next_queue = 4'h0;
         end
      endcase
   end
   // ==========================================
   // Result register
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         res_out <= '0;
      end else begin
         res_out.valid <= s2.valid;
         res_out.queue <= next_queue;
         res_out.to_master <= s2.valid && master_act;
         res_out.to_local <= s2.valid && local_act;
         res_out.cfg_err <= s2.valid && s2.src != SPQM_SRC_DATA && fast_sel && fast_bad;
         res_out.pri <= s2.pri;
      end
   end
   // ==========================================
   // Status: sticky error and count
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         err_seen <= 1'b0;
         err_count <= 32'h0000_0000;
      end else begin
         if (s2.valid && s2.src != SPQM_SRC_DATA && fast_sel && fast_bad) begin
            err_seen <= 1'b1;
            err_count <= err_count + 32'h0000_0001;
         end else if (wr_in && addr_in == `SPQM_ADDR_STAT && wdata_in[0]) begin
            err_seen <= 1'b0;
         end
      end
   end
   // ==========================================
   // Read data, one cycle after the strobe
   logic [7:0] rd_addr;
   logic rd_q;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_addr <= 8'h00;
         rd_q <= 1'b0;
      end else begin
         rd_addr <= addr_in;
         rd_q <= rd_in;
      end
   end
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (in_tab(rd_addr, `SPQM_BASE_PRI, `SPQM_PRI_N)) begin
         next_rdata = {29'h0, pri_rd};
      end else if (in_tab(rd_addr, `SPQM_BASE_NQ, `SPQM_CPUQ_N)) begin
         next_rdata = {29'h0, nq_rd};
      end else if (in_tab(rd_addr, `SPQM_BASE_FQ, `SPQM_CPUQ_N)) begin
         next_rdata = {28'h0, fq_rd};
      end else if (in_tab(rd_addr, `SPQM_BASE_TRAP, `SPQM_REASON_N)) begin
         next_rdata = {27'h0, trap_rd};
      end else if (rd_addr == `SPQM_ADDR_CTRL) begin
         next_rdata = {31'h0, first_dev};
      end else if (rd_addr == `SPQM_ADDR_STAT) begin
         next_rdata = {err_count[30:0], err_seen};
      end
   end
   // Table read data are registered, so the bus mux is combinational after them
   always_comb begin
      rdata_out = rd_q ? next_rdata : 32'h0000_0000;
   end
   // ==========================================
   // Assertions
   property p_data_low;
      @(posedge clk_in) disable iff (rst_in)
      $past(s2.valid) && $past(s2.src) == SPQM_SRC_DATA |-> res_out.queue <= `SPQM_DATA_MAX;
   endproperty
   a_data_low: assert property (p_data_low) else $error("data queue above seven");
   property p_fast_range;
      @(posedge clk_in) disable iff (rst_in)
      res_out.valid |-> res_out.queue < `SPQM_FAST_Q;
   endproperty
   a_fast_range: assert property (p_fast_range) else $error("queue beyond twelve");
   property p_normal_range;
      @(posedge clk_in) disable iff (rst_in)
      $past(s2.valid) && !$past(fast_sel) |-> res_out.queue < `SPQM_NORMAL_Q;
   endproperty
   a_normal_range: assert property (p_normal_range) else $error("normal port queue beyond eight");
   property p_err_clamp;
      @(posedge clk_in) disable iff (rst_in)
      res_out.cfg_err |-> res_out.queue == `SPQM_FAST_MAX;
   endproperty
   a_err_clamp: assert property (p_err_clamp) else $error("invalid code not clamped");
   property p_master_flag;
      @(posedge clk_in) disable iff (rst_in)
      req_in.valid && req_in.act == SPQM_ACT_TRAP_MASTER |-> ##3 res_out.to_master && !res_out.to_local;
   endproperty
   a_master_flag: assert property (p_master_flag) else $error("trap to master lost");
   property p_pri_carry;
      @(posedge clk_in) disable iff (rst_in)
      req_in.valid |-> ##3 res_out.valid && res_out.pri == $past(req_in.pri, 3);
   endproperty
   a_pri_carry: assert property (p_pri_carry) else $error("priority not carried");
   property p_err_sticky;
      @(posedge clk_in) disable iff (rst_in)
      res_out.cfg_err |-> err_seen;
   endproperty
   a_err_sticky: assert property (p_err_sticky) else $error("error not recorded");
   property p_trap_fast;
      @(posedge clk_in) disable iff (rst_in)
      s2.valid && s2.src == SPQM_SRC_TRAP && master_act |-> fast_sel;
   endproperty
   a_trap_fast: assert property (p_trap_fast) else $error("master trap not on stacking map");
   property p_pri_field;
      @(posedge clk_in) disable iff (rst_in)
      $past(rd_in) && in_tab($past(addr_in), `SPQM_BASE_PRI, `SPQM_PRI_N) |-> rdata_out[31:3] == 29'h0;
   endproperty
   a_pri_field: assert property (p_pri_field) else $error("priority map entry wider than three bits");
   property p_nq_field;
      @(posedge clk_in) disable iff (rst_in)
      $past(rd_in) && in_tab($past(addr_in), `SPQM_BASE_NQ, `SPQM_CPUQ_N) |-> rdata_out[31:3] == 29'h0;
   endproperty
   a_nq_field: assert property (p_nq_field) else $error("normal map entry wider than three bits");
   property p_fq_field;
      @(posedge clk_in) disable iff (rst_in)
      $past(rd_in) && in_tab($past(addr_in), `SPQM_BASE_FQ, `SPQM_CPUQ_N) |-> rdata_out[31:4] == 28'h0;
   endproperty
   a_fq_field: assert property (p_fq_field) else $error("fast map entry wider than four bits");
   property p_trap_field;
      @(posedge clk_in) disable iff (rst_in)
      $past(rd_in) && in_tab($past(addr_in), `SPQM_BASE_TRAP, `SPQM_REASON_N) |-> rdata_out[31:5] == 27'h0;
   endproperty
   a_trap_field: assert property (p_trap_field) else $error("trap queue entry wider than five bits");
   property p_data_no_err;
      @(posedge clk_in) disable iff (rst_in)
      $past(s2.valid) && $past(s2.src) == SPQM_SRC_DATA |-> !res_out.cfg_err;
   endproperty
   a_data_no_err: assert property (p_data_no_err) else $error("data packet flagged as config error");
   property p_normal_no_err;
      @(posedge clk_in) disable iff (rst_in)
      $past(s2.valid) && !$past(fast_sel) |-> !res_out.cfg_err;
   endproperty
   a_normal_no_err: assert property (p_normal_no_err) else $error("normal map flagged as config error");
   property p_fast_pass;
      @(posedge clk_in) disable iff (rst_in)
      $past(s2.valid) && $past(s2.src) != SPQM_SRC_DATA && $past(fast_sel) && !$past(fast_bad) |->
         res_out.queue == $past(fq_q);
   endproperty
   a_fast_pass: assert property (p_fast_pass) else $error("valid fast code not passed through");
   property p_err_count;
      @(posedge clk_in) disable iff (rst_in)
      res_out.cfg_err |-> err_count == $past(err_count) + 32'h0000_0001;
   endproperty
   a_err_count: assert property (p_err_count) else $error("config error not counted");
   property p_copy_master;
      @(posedge clk_in) disable iff (rst_in)
      req_in.valid && req_in.act == SPQM_ACT_COPY_MASTER |-> ##3 res_out.to_master && res_out.to_local;
   endproperty
   a_copy_master: assert property (p_copy_master) else $error("copy to master flags wrong");
   property p_fwd_plain;
      @(posedge clk_in) disable iff (rst_in)
      req_in.valid && req_in.act == SPQM_ACT_FWD |-> ##3 !res_out.to_master && !res_out.to_local;
   endproperty
   a_fwd_plain: assert property (p_fwd_plain) else $error("forwarded packet marked for processor");
   property p_data_map;
      @(posedge clk_in) disable iff (rst_in)
      $past(s2.valid) && $past(s2.src) == SPQM_SRC_DATA |-> res_out.queue == {1'b0, $past(pri_q)};
   endproperty
   a_data_map: assert property (p_data_map) else $error("data queue not from priority map");
endmodule // spqm_mapper

// ===== spqm_stack_neighbour.sv
// Neighbouring stack device model receiving egress results
`timescale 1ns/1ps
module spqm_stack_neighbour import spqm_pkg::*; (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Results arriving over the stacking port
   input wire spqm_res_type res_in,
   // Receive status
   output logic [15:0] rx_count_out,
   output logic bad_queue_out
);
   // ==========================================
   // Packet count
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_count_out <= 16'h0000;
      end else if (res_in.valid) begin
         rx_count_out <= rx_count_out + 16'h0001;
      end
   end
   // ==========================================
   // Queues past eleven do not exist on any port
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         bad_queue_out <= 1'b0;
      end else if (res_in.valid && (res_in.queue > 4'hB)) begin
         bad_queue_out <= 1'b1;
      end
   end
endmodule // spqm_stack_neighbour

// ===== test_spqm_mapper.sv
// Testbench for the stacking port queue mapper
`timescale 1ns/1ps
`include "spqm_consts.svh"
module test_spqm_mapper import spqm_pkg::*; ;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic rd_d = 1'b0;
   logic bad;
   logic [7:0] addr_in = 8'h00;
   logic [31:0] wdata_in = 32'h0;
   logic [31:0] rdata_out;
   logic [15:0] rx_count;
   spqm_req_type req_in = '0;
   spqm_res_type res_out;
   spqm_req_type r;
   int errors = 0;
   int cmp_count = 0;
   int seed = 19334;
   int sent = 0;
   int nerr = 0;
   int nclr = 0;
   logic [2:0] pri_m [8];
   logic [2:0] nq_m [32];
   logic [3:0] fq_m [32];
   logic [4:0] tq_m [32];
   logic [31:0] rd_q [$];
   spqm_res_type res_q [$];
   spqm_mapper u_spqm_mapper (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .req_in(req_in), .res_out(res_out));
   spqm_stack_neighbour u_spqm_stack_neighbour (.clk_in(clk_in), .rst_in(rst_in), .res_in(res_out),
      .rx_count_out(rx_count), .bad_queue_out(bad));
   // ==========================================
   // Checking and closing
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("Counts: %0d compares, %0d mismatches", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   function automatic spqm_res_type exp_res(input spqm_req_type p);
      spqm_res_type e;
      logic [4:0] q;
      e = '0;
      e.valid = 1'b1;
      e.pri = p.pri;
      e.to_master = (p.act == SPQM_ACT_TRAP_MASTER) || (p.act == SPQM_ACT_COPY_MASTER);
      e.to_local = (p.act == SPQM_ACT_TRAP_LOCAL) || (p.act == SPQM_ACT_COPY_LOCAL) || (p.act == SPQM_ACT_COPY_MASTER);
      q = (p.src == SPQM_SRC_TRAP) ? tq_m[p.reason] : p.cpu_q;
      if (p.src == SPQM_SRC_DATA) begin
         e.queue = {1'b0, pri_m[p.pri]};
      end else if (p.fast_port || (p.src == SPQM_SRC_TRAP && e.to_master)) begin
         e.cfg_err = fq_m[q] > `SPQM_FAST_MAX;
         e.queue = e.cfg_err ? `SPQM_FAST_MAX : fq_m[q];
      end else begin
         e.queue = {1'b0, nq_m[q]};
      end
      return e;
   endfunction
   // ==========================================
   // Bus and request drivers
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      rd_in <= 1'b0;
      req_in <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_in);
      addr_in <= a;
      wr_in <= 1'b0;
      rd_in <= 1'b1;
      req_in <= '0;
      rd_q.push_back(e);
   endtask
   task automatic wt(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
      wr(a, d);
      rd(a, d & m);
   endtask
   task automatic send(input spqm_req_type p);
      spqm_res_type e;
      e = exp_res(p);
      @(posedge clk_in);
      wr_in <= 1'b0;
      rd_in <= 1'b0;
      req_in <= p;
      res_q.push_back(e);
      sent++;
      if (e.cfg_err) nerr++;
   endtask
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clk_in);
         wr_in <= 1'b0;
         rd_in <= 1'b0;
         req_in <= '0;
      end
   endtask
   task automatic cfg_rand();
      logic [31:0] d;
      for (int i = 0; i < 32; i++) begin
         d = $random(seed);
         if (i < 8) begin
            pri_m[i] = d[2:0];
            wt(`SPQM_BASE_PRI + 8'(i), d, 32'h7);
         end
         nq_m[i] = d[10:8];
         wt(`SPQM_BASE_NQ + 8'(i), d >> 8, 32'h7);
         fq_m[i] = d[19:16];
         wt(`SPQM_BASE_FQ + 8'(i), d >> 16, 32'hF);
         tq_m[i] = d[28:24];
         wt(`SPQM_BASE_TRAP + 8'(i), d >> 24, 32'h1F);
      end
   endtask
   // ==========================================
   // Result watcher
   always @(posedge clk_in) rd_d <= rd_in;
   always @(negedge clk_in) begin
      if (rd_d) chk(rdata_out, rd_q.pop_front());
      if (res_out.valid === 1'b1) chk({21'h0, res_out}, {21'h0, res_q.pop_front()});
   end
   // ==========================================
   // Clock, watchdog and sequence
   initial begin
      forever #5 clk_in = ~clk_in;
   end
   initial begin
      #200000;
      errors++;
      conclude();
   end
   initial begin
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      rd(`SPQM_ADDR_CTRL, 32'h1);
      rd(`SPQM_BASE_FQ + 8'h05, 32'h0);
      wr(8'h90, 32'hFFFF_FFFF);
      rd(8'h90, 32'h0);
      idle(2);
      $display("Test reset values done");
      for (int n = 0; n < 4; n++) begin
         cfg_rand();
         wt(`SPQM_ADDR_CTRL, 32'(n[0]), 32'h1);
         idle(4);
         for (int k = 0; k < 60; k++) begin
            r = spqm_req_type'(20'($random(seed)));
            r.valid = 1'b1;
            r.src = spqm_src_type'(k % 3);
            r.act = spqm_act_type'((k / 3) % 5);
            send(r);
         end
         idle(5);
         rd(`SPQM_ADDR_STAT, {nerr[30:0], 1'(nerr != nclr)});
         wr(`SPQM_ADDR_STAT, 32'h1);
         nclr = nerr;
         rd(`SPQM_ADDR_STAT, {nerr[30:0], 1'b0});
         idle(2);
         $display("Test round %0d done", n);
      end
      chk({16'h0, rx_count}, 32'(sent));
      chk({31'h0, bad}, 32'h0);
      conclude();
   end
endmodule // test_spqm_mapper
